/* include/ptb_pkg.sv */
package ptb_pkg;

  localparam logic [3:0] PTB_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] PTB_ADDR_COUNT   = 4'h4;
  localparam logic [3:0] PTB_ADDR_PERIOD  = 4'h8;
  localparam logic [3:0] PTB_ADDR_STATUS  = 4'hC;

  localparam int PTB_ENABLE_BIT  = 15;
  localparam int PTB_POST_LSB    = 4;
  localparam int PTB_PRE_LSB     = 2;
  localparam int PTB_MODE_LSB    = 0;
  localparam int PTB_DIR_BIT     = 15;

  localparam logic [15:0] PTB_CONTROL_RESET = 16'h0000;
  localparam logic [14:0] PTB_COUNT_RESET   = 15'h0000;
  localparam logic [14:0] PTB_PERIOD_RESET  = 15'h7fff;
  localparam logic [14:0] PTB_COUNT_ONE     = 15'h0001;
  localparam logic [3:0]  PTB_POST_ZERO     = 4'h0;

  localparam logic [5:0] PTB_PRE_DIV1  = 6'h00;
  localparam logic [5:0] PTB_PRE_DIV4  = 6'h03;
  localparam logic [5:0] PTB_PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PTB_PRE_DIV64 = 6'h3f;

  typedef enum logic [1:0] {
    PTB_MODE_FREE   = 2'b00,
    PTB_MODE_SINGLE = 2'b01,
    PTB_MODE_UPDN   = 2'b10,
    PTB_MODE_UPDN2  = 2'b11
  } ptb_mode_t;

  typedef enum logic [1:0] {
    PTB_BUS_IDLE = 2'b00,
    PTB_BUS_DONE = 2'b01
  } ptb_bus_t;

  typedef struct packed {
    logic        enable;
    logic [3:0]  output_postscale_select;
    logic [1:0]  input_clock_prescale_select;
    ptb_mode_t   mode;
  } ptb_ctrl_t;

  typedef struct packed {
    ptb_ctrl_t   ctrl;
    logic [14:0] time_base_count_value;
    logic        count_direction_flag;
    logic [14:0] period;
    logic [5:0]  pre_cnt;
    logic [3:0]  post_cnt;
    logic        event_sticky;
    logic        event_pulse;
    ptb_bus_t    bus;
    logic [31:0] readdata;
  } ptb_state_t;

endpackage : ptb_pkg

/* hw/ptb_time_base.sv */
// Behaviour
// - Output events divide by postscale code plus one, 1:1 up to 1:16.
// - Prescale code selects count period of 1, 4, 16 or 64 cycles.
// - Count register top bit shows direction, read-only, resets to zero.
// - Direction bit is one counting down and zero counting up.
// - Low fifteen count bits are read-write and reset to zero.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module ptb_time_base (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             tb_event_o,
  output logic             tb_running_o
);
  import ptb_pkg::*;

  ptb_state_t st;
  ptb_state_t next_st;

  function automatic logic [5:0] pre_limit(input logic [1:0] code);
    case (code)
      2'b00:   pre_limit = PTB_PRE_DIV1;
      2'b01:   pre_limit = PTB_PRE_DIV4;
      2'b10:   pre_limit = PTB_PRE_DIV16;
      default: pre_limit = PTB_PRE_DIV64;
    endcase
  endfunction : pre_limit

  ////////////////////////////////////////////////////////////////////////////
  logic        tick;
  logic        period_hit;
  logic        req;
  logic [15:0] wdata;
  logic [15:0] ctrl_rd;
  logic        hw_event_q;
  logic        req_q;

  assign tick       = st.ctrl.enable && (st.pre_cnt == pre_limit(st.ctrl.input_clock_prescale_select));
  assign period_hit = (st.time_base_count_value == st.period);
  assign req        = (avs_read_i || avs_write_i) && (st.bus == PTB_BUS_IDLE);
  assign wdata      = {avs_byteenable_i[1] ? avs_writedata_i[15:8] : 8'h00,
                       avs_byteenable_i[0] ? avs_writedata_i[7:0]  : 8'h00};
  assign ctrl_rd    = {st.ctrl.enable, 7'h00, st.ctrl.output_postscale_select,
                       st.ctrl.input_clock_prescale_select, st.ctrl.mode};

  always_comb begin
    logic hw_event;
    hw_event = 1'b0;
    next_st = st;
    next_st.event_pulse = 1'b0;

    // Prescaler runs only while enabled.
    if (!st.ctrl.enable) begin
      next_st.pre_cnt = '0;
    end else if (tick) begin
      next_st.pre_cnt = '0;
    end else begin
      next_st.pre_cnt = st.pre_cnt + 6'h01;
    end

    if (tick) begin
      case (st.ctrl.mode)
        PTB_MODE_FREE: begin
          if (period_hit) begin
            next_st.time_base_count_value = PTB_COUNT_RESET;
            hw_event = 1'b1;
          end else begin
            next_st.time_base_count_value = st.time_base_count_value + PTB_COUNT_ONE;
          end
        end
        PTB_MODE_SINGLE: begin
          // Single event stops and disables the base once period is reached.
          if (period_hit) begin
            next_st.time_base_count_value = PTB_COUNT_RESET;
            next_st.ctrl.enable = 1'b0;
            hw_event = 1'b1;
          end else begin
            next_st.time_base_count_value = st.time_base_count_value + PTB_COUNT_ONE;
          end
        end
        PTB_MODE_UPDN, PTB_MODE_UPDN2: begin
          if (!st.count_direction_flag) begin
            if (period_hit) begin
              next_st.count_direction_flag = 1'b1;
              next_st.time_base_count_value = st.time_base_count_value - PTB_COUNT_ONE;
              hw_event = (st.ctrl.mode == PTB_MODE_UPDN2);
            end else begin
              next_st.time_base_count_value = st.time_base_count_value + PTB_COUNT_ONE;
            end
          end else begin
            if (st.time_base_count_value == PTB_COUNT_RESET) begin
              next_st.count_direction_flag = 1'b0;
              next_st.time_base_count_value = PTB_COUNT_ONE;
              hw_event = 1'b1;
            end else begin
              next_st.time_base_count_value = st.time_base_count_value - PTB_COUNT_ONE;
            end
          end
        end
        default: begin
          next_st.time_base_count_value = st.time_base_count_value;
        end
      endcase
    end

    // Postscaler passes one event in every code plus one.
    if (hw_event) begin
      if (st.post_cnt == st.ctrl.output_postscale_select) begin
        next_st.post_cnt    = PTB_POST_ZERO;
        next_st.event_pulse = 1'b1;
      end else begin
        next_st.post_cnt = st.post_cnt + 4'h1;
      end
    end

    // Bus: every access takes one wait cycle; status read clears sticky.
    next_st.bus = PTB_BUS_IDLE;
    if (req) begin
      next_st.bus = PTB_BUS_DONE;
      next_st.readdata = '0;
      if (avs_write_i) begin
        case (avs_address_i)
          PTB_ADDR_CONTROL: begin
            next_st.ctrl.enable = wdata[PTB_ENABLE_BIT];
            next_st.ctrl.output_postscale_select = wdata[PTB_POST_LSB +: 4];
            next_st.ctrl.input_clock_prescale_select = wdata[PTB_PRE_LSB +: 2];
            next_st.ctrl.mode = ptb_mode_t'(wdata[PTB_MODE_LSB +: 2]);
            next_st.post_cnt = PTB_POST_ZERO;
            // Free-running and single event only count up, so a stale down flag is dropped.
            if (next_st.ctrl.mode == PTB_MODE_FREE || next_st.ctrl.mode == PTB_MODE_SINGLE) begin
              next_st.count_direction_flag = 1'b0;
            end
          end
          PTB_ADDR_COUNT: begin
            next_st.time_base_count_value = wdata[14:0];
          end
          PTB_ADDR_PERIOD: begin
            next_st.period = wdata[14:0];
          end
          default: begin
            next_st.bus = PTB_BUS_DONE;
          end
        endcase
      end else begin
        case (avs_address_i)
          PTB_ADDR_CONTROL: next_st.readdata = {16'h0000, ctrl_rd};
          PTB_ADDR_COUNT:   next_st.readdata = {16'h0000, st.count_direction_flag,
                                                st.time_base_count_value};
          PTB_ADDR_PERIOD:  next_st.readdata = {17'h0_0000, st.period};
          PTB_ADDR_STATUS: begin
            next_st.readdata = {31'h0000_0000, st.event_sticky};
            next_st.event_sticky = 1'b0;
          end
          default:          next_st.readdata = '0;
        endcase
      end
    end
    if (next_st.event_pulse) begin
      next_st.event_sticky = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st.ctrl                  <= ptb_ctrl_t'({PTB_CONTROL_RESET[PTB_ENABLE_BIT],
                                               PTB_CONTROL_RESET[7:0]});
      st.time_base_count_value <= PTB_COUNT_RESET;
      st.count_direction_flag  <= 1'b0;
      st.period                <= PTB_PERIOD_RESET;
      st.pre_cnt               <= PTB_PRE_DIV1;
      st.post_cnt              <= PTB_POST_ZERO;
      st.event_sticky          <= 1'b0;
      st.event_pulse           <= 1'b0;
      st.bus                   <= PTB_BUS_IDLE;
      st.readdata              <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (st.bus == PTB_BUS_IDLE);
  assign avs_readdata_o    = st.readdata;
  assign tb_event_o        = st.event_pulse;
  assign tb_running_o      = st.ctrl.enable;

  ////////////////////////////////////////////////////////////////////////////
  AST_PRESCALE_GAP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (tick && st.ctrl.input_clock_prescale_select == 2'b01 && !req) |=>
      (!tick [*3]))
    else $error("Prescale 1:4 ticked early.");

  AST_DIR_UP_COUNTS_UP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (tick && !req && st.ctrl.mode == PTB_MODE_UPDN && !st.count_direction_flag && !period_hit)
      |=> (st.time_base_count_value == $past(st.time_base_count_value) + PTB_COUNT_ONE))
    else $error("Up direction did not increment.");

  AST_DIR_DOWN_COUNTS_DOWN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (tick && !req && st.count_direction_flag && st.time_base_count_value != PTB_COUNT_RESET)
      |=> (st.time_base_count_value == $past(st.time_base_count_value) - PTB_COUNT_ONE))
    else $error("Down direction did not decrement.");

  AST_DIR_READ_ONLY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (req && avs_write_i && avs_address_i == PTB_ADDR_COUNT && !tick)
      |=> $stable(st.count_direction_flag))
    else $error("Direction bit changed by software.");

  AST_COUNT_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (req && avs_write_i && avs_address_i == PTB_ADDR_COUNT && avs_byteenable_i[1:0] == 2'b11)
      |=> (st.time_base_count_value == $past(avs_writedata_i[14:0])))
    else $error("Count write not stored.");

  AST_POST_1TO1: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (hw_event_q && st.ctrl.output_postscale_select == PTB_POST_ZERO && !req_q) |-> tb_event_o)
    else $error("1:1 postscale dropped an event.");

  AST_FREE_WRAP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (tick && !req && st.ctrl.mode == PTB_MODE_FREE && period_hit)
      |=> (st.time_base_count_value == PTB_COUNT_RESET))
    else $error("Free-running mode did not wrap.");

  AST_SINGLE_STOP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (tick && !req && st.ctrl.mode == PTB_MODE_SINGLE && period_hit) |=> !st.ctrl.enable)
    else $error("Single event mode did not stop.");

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hw_event_q <= 1'b0;
      req_q      <= 1'b0;
    end else begin
      // Expected raw event per mode: top in free, single and double update; bottom in both up/down modes.
      hw_event_q <= tick && (((st.ctrl.mode == PTB_MODE_FREE || st.ctrl.mode == PTB_MODE_SINGLE)
                              && period_hit)
                             || ((st.ctrl.mode == PTB_MODE_UPDN || st.ctrl.mode == PTB_MODE_UPDN2)
                                 && st.count_direction_flag
                                 && st.time_base_count_value == PTB_COUNT_RESET)
                             || (st.ctrl.mode == PTB_MODE_UPDN2 && !st.count_direction_flag
                                 && period_hit));
      req_q      <= req;
    end
  end

endmodule : ptb_time_base
`default_nettype wire

/* dv/tb_ptb_time_base.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_ptb_time_base;
  import ptb_pkg::*;
  logic        core_clk_i;
  logic        rst_b_i;
  logic [3:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        tb_event_o;
  logic        tb_running_o;
  int          failures;
  int          cmp_count;

  ptb_time_base ptb_time_base_i (
    .core_clk_i       (core_clk_i),
    .rst_b_i          (rst_b_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .tb_event_o       (tb_event_o),
    .tb_running_o     (tb_running_o)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // One Avalon transfer; entered just after a rising edge, leaves one idle cycle.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i    <= a;
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    avs_writedata_i  <= d;
    avs_byteenable_i <= 4'hf;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (avs_waitrequest_o !== 1'b0) begin
      failures++;
      final_report();
    end
    q = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  function automatic logic [31:0] ctl(input logic [3:0] po, input logic [1:0] pr,
                                      input logic [1:0] md);
    return {16'h0000, 1'b1, 7'h00, po, pr, md};
  endfunction : ctl

  // Cycles between postscaled events for a given number of counter ticks per event.
  function automatic int exp_gap(input logic [1:0] pr, input logic [3:0] po, input int ticks);
    int div;
    div = (pr == 2'b00) ? 1 : (pr == 2'b01) ? 4 : (pr == 2'b10) ? 16 : 64;
    return ticks * div * (int'(po) + 1);
  endfunction : exp_gap

  task automatic wait_ev;
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (tb_event_o !== 1'b1 && n < 20000);
    if (tb_event_o !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask : wait_ev

  // Cycles between two full postscaled events after a control write.
  task automatic gap(input logic [31:0] c, output int g);
    wr(PTB_ADDR_CONTROL, c);
    wait_ev();
    g = 0;
    do begin
      @(posedge core_clk_i);
      g++;
    end while (tb_event_o !== 1'b1 && g < 20000);
    if (tb_event_o !== 1'b1) begin
      failures++;
      final_report();
    end
  endtask : gap

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [31:0] q0;
    logic [14:0] v;
    logic [3:0]  po;
    int          g0;
    int          g;
    int          gu;
    void'($urandom(30126));
    failures = 0;
    cmp_count = 0;
    rst_b_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    @(posedge core_clk_i);
    rd(PTB_ADDR_CONTROL, q);
    `CHK("control reset", {16'h0000, PTB_CONTROL_RESET}, q)
    rd(PTB_ADDR_COUNT, q);
    `CHK("count reset", 32'h0000_0000, q)
    wr(4'h2, 32'hffff_ffff);
    rd(4'h2, q);
    `CHK("unmapped", 32'h0000_0000, q)
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 15'h7fff : 15'($urandom);
      wr(PTB_ADDR_COUNT, {16'h0000, 1'b1, v});
      rd(PTB_ADDR_COUNT, q);
      `CHK("count value", {16'h0000, 1'b0, v}, q)
    end
    wr(PTB_ADDR_PERIOD, 32'h0000_0002);
    // A leftover count above the period would take a full wrap before the first event.
    wr(PTB_ADDR_COUNT, 32'h0000_0000);
    gap(ctl(4'h0, 2'b00, PTB_MODE_FREE), g0);
    `CHK("base gap", exp_gap(2'b00, 4'h0, 3), g0)
    for (int p = 1; p < 4; p++) begin
      gap(ctl(4'h0, 2'(p), PTB_MODE_FREE), g);
      `CHK("prescaled gap", exp_gap(2'(p), 4'h0, 3), g)
    end
    for (int i = 0; i < 4; i++) begin
      po = (i == 0) ? 4'hf : 4'($urandom_range(1, 14));
      gap(ctl(po, 2'b00, PTB_MODE_FREE), g);
      `CHK("postscaled gap", exp_gap(2'b00, po, 3), g)
    end
    gap(ctl(4'h0, 2'b00, PTB_MODE_UPDN), gu);
    `CHK("up down gap", exp_gap(2'b00, 4'h0, 4), gu)
    gap(ctl(4'h0, 2'b00, PTB_MODE_UPDN2), g);
    `CHK("double update gap", exp_gap(2'b00, 4'h0, 2), g)
    wr(PTB_ADDR_PERIOD, 32'h0000_0003);
    wr(PTB_ADDR_CONTROL, ctl(4'h0, 2'b11, PTB_MODE_UPDN));
    rd(PTB_ADDR_COUNT, q0);
    repeat (200) begin
      rd(PTB_ADDR_COUNT, q);
      if (q[14:0] > q0[14:0]) begin
        `CHK("direction up", 1'b0, q[15])
      end else if (q[14:0] < q0[14:0]) begin
        `CHK("direction down", 1'b1, q[15])
      end
      q0 = q;
    end
    wr(PTB_ADDR_COUNT, 32'h0000_0000);
    wr(PTB_ADDR_CONTROL, ctl(4'h0, 2'b00, PTB_MODE_SINGLE));
    wait_ev();
    repeat (8) @(posedge core_clk_i);
    `CHK("single running", 1'b0, tb_running_o)
    rd(PTB_ADDR_CONTROL, q);
    `CHK("single enable", 1'b0, q[PTB_ENABLE_BIT])
    rd(PTB_ADDR_STATUS, q);
    `CHK("event sticky", 32'h0000_0001, q)
    rd(PTB_ADDR_STATUS, q);
    `CHK("sticky cleared", 32'h0000_0000, q)
    final_report();
  end
endmodule : tb_ptb_time_base
`default_nettype wire
